// ==== brc_burst_read_config.sv ====
// Purpose: burst read engine of a 16-bit nonvolatile array with its configuration register
// Assumes: link clock far slower than clk_i; host keeps its side of the link protocol
// Notes:   array, configuration and status reached over classic Wishbone
//
// Operation
// RULE1: wait code 1000 gives data at edge 8
// RULE2: wait code 1001 gives data at edge 9
// RULE3: codes 0100 and 0101 give edges 6, 7
// RULE4: polarity bit sets ready level, default high
// RULE5: timing bit: ready early or with data
// RULE6: mode bit stays legacy, other code reserved
// RULE7: wrap bit set wraps fixed bursts in group
// RULE8: wrap bit clear advances linearly, then stops
// RULE9: continuous default, code 011 is 16 words
// RULE10: code 010 selects an 8-word burst
// RULE11: host writes reserved bits nine, seven as 1
// RULE12: host avoids reserved codes, waits programmed edges
// RULE13: new settings apply from next burst start
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "brc_defs.svh"
`default_nettype none

// ****************************************
// word fifo
// ****************************************
module brc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       flush_i,
  // filling side
  input  wire logic [WIDTH-1:0]           in_data_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  // draining side
  output logic [WIDTH-1:0]                out_data_o,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [$clog2(DEPTH+1)-1:0]      count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0]            store [DEPTH];
  logic [AW-1:0]               wr_ptr;
  logic [AW-1:0]               rd_ptr;
  logic [$clog2(DEPTH+1)-1:0]  count;
  wire                         do_push = in_valid_i & in_ready_o;
  wire                         do_pop  = out_valid_o & out_ready_i;

  // honest full and empty from the occupancy count
  assign in_ready_o  = (count != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = store[rd_ptr];
  assign count_o     = count;

  // pointers wrap at depth, so depth need not be a power of two
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (do_pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + {{($clog2(DEPTH+1)-1){1'b0}}, do_push}
                     - {{($clog2(DEPTH+1)-1){1'b0}}, do_pop};
    end
  end

  // storage needs no reset
  always_ff @(posedge clk_i) begin
    if (do_push) store[wr_ptr] <= in_data_i;
  end
endmodule : brc_fifo

// ****************************************
// burst read block
// ****************************************
module brc_burst_read_config
  import brc_pkg::*;
#(
  parameter int ADDR_W     = 6,
  parameter int FIFO_DEPTH = 8
) (
  // system clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [3:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // burst link pins
  input  wire logic               burst_clk_i,
  input  wire logic               chip_enable_n_i,
  input  wire logic               addr_latch_n_i,
  input  wire logic               output_enable_n_i,
  input  wire logic [ADDR_W-1:0]  addr_i,
  output logic      [15:0]        burst_data_o,
  output logic                    burst_data_oe_o,
  output logic                    ready_o
);
  localparam int CW = $clog2(FIFO_DEPTH+1);

  // first-word edge number for a wait-state code; reserved codes take the longest
  function automatic logic [3:0] first_edge(input logic [3:0] code);
    unique case (code)
      `BRC_WAIT_6: first_edge = `BRC_EDGES_6; // RULE3
      `BRC_WAIT_7: first_edge = `BRC_EDGES_7; // RULE3
      `BRC_WAIT_8: first_edge = `BRC_EDGES_8; // RULE1
      `BRC_WAIT_9: first_edge = `BRC_EDGES_9; // RULE2
      default:     first_edge = `BRC_EDGES_9;
    endcase
  endfunction : first_edge

  // ****************************************
  // register file
  // ****************************************
  logic [15:0]        burst_read_configuration;
  logic [ADDR_W-1:0]  arr_index;
  logic [15:0]        arr [2**ADDR_W];
  logic               ack;
  logic [31:0]        rd_data;
  logic [15:0]        status_word;

  wire        bus_req  = wb_cyc_i & wb_stb_i;
  wire        wr_take  = bus_req & wb_we_i & ack;
  wire        hit_cfg  = (wb_adr_i == `BRC_OFF_CONFIG);
  wire        hit_stat = (wb_adr_i == `BRC_OFF_STATUS);
  wire        hit_idx  = (wb_adr_i == `BRC_OFF_ARR_INDEX);
  wire        hit_dat  = (wb_adr_i == `BRC_OFF_ARR_DATA);
  wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // mode bit is read-only legacy, so the reserved encoding can never be stored
  wire [15:0] cfg_wmask = lane_mask & `BRC_CONFIG_WMASK;
  wire [15:0] next_cfg  = (burst_read_configuration & ~cfg_wmask)
                        | (wb_dat_i[15:0] & cfg_wmask) | `BRC_MODE_LEGACY; // RULE6

  // read mux; unmapped offsets answer zero
  assign rd_data = hit_cfg  ? {16'h0000, burst_read_configuration} :
                   hit_stat ? {16'h0000, status_word} :
                   hit_idx  ? {{(32-ADDR_W){1'b0}}, arr_index} :
                   hit_dat  ? {16'h0000, arr[arr_index]} : 32'h0000_0000;

  // one wait state per access; ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack      <= bus_req & ~ack;
      wb_ack_o <= bus_req & ~ack;
      if (bus_req & ~ack) wb_dat_o <= rd_data;
    end
  end

  // writes land on the edge where the master sees ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      burst_read_configuration <= `BRC_CONFIG_RESET; // RULE4 RULE5 RULE8 RULE9
      arr_index                <= '0;
    end else if (wr_take) begin
      if (hit_cfg) burst_read_configuration <= next_cfg;
      if (hit_idx && wb_sel_i[0]) arr_index <= wb_dat_i[ADDR_W-1:0];
      if (hit_dat) arr_index <= arr_index + 1'b1;
    end
  end

  // array words, loaded through the data window
  always_ff @(posedge clk_i) begin
    if (wr_take && hit_dat && (&wb_sel_i[1:0])) arr[arr_index] <= wb_dat_i[15:0];
  end

  // ****************************************
  // link pin synchronisers
  // ****************************************
  logic [ADDR_W+3:0] pin_meta;
  logic [ADDR_W+3:0] pin_sync;
  logic              clk_seen;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '1;
      pin_sync <= '1;
      clk_seen <= 1'b1;
    end else begin
      pin_meta <= {addr_i, output_enable_n_i, addr_latch_n_i, chip_enable_n_i, burst_clk_i};
      pin_sync <= pin_meta;
      clk_seen <= pin_sync[0];
    end
  end
  wire              link_rise = pin_sync[0] & ~clk_seen;
  wire              ce_on     = ~pin_sync[1];
  wire              latch_on  = ~pin_sync[2];
  wire              oe_on     = ~pin_sync[3];
  wire [ADDR_W-1:0] link_addr = pin_sync[ADDR_W+3:4];
  wire              start     = link_rise & ce_on & latch_on;

  // ****************************************
  // fetch engine: array into fifo
  // ****************************************
  logic              fetch_on;
  logic [ADDR_W-1:0] fetch_addr;
  logic [4:0]        fetch_cnt;
  logic              snap_wrap;
  logic [2:0]        snap_len;
  logic              fifo_in_ready;
  logic [15:0]       fifo_out;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [CW-1:0]     fifo_count;

  wire        fixed_len = (snap_len == `BRC_LEN_8) || (snap_len == `BRC_LEN_16); // RULE10
  wire [4:0]  len_words = (snap_len == `BRC_LEN_16) ? 5'h10 : 5'h08; // RULE9
  wire [ADDR_W-1:0] grp_mask = ADDR_W'(len_words - 5'h01);
  wire        linear_done = fixed_len & ~snap_wrap & (fetch_cnt == len_words); // RULE8
  wire        fetch_push  = fetch_on & ~linear_done;
  wire [ADDR_W-1:0] addr_inc  = fetch_addr + 1'b1;
  // wrapping keeps the upper address bits and cycles inside the aligned group
  wire [ADDR_W-1:0] next_addr = (fixed_len & snap_wrap) ?
                                ((fetch_addr & ~grp_mask) | (addr_inc & grp_mask)) : // RULE7
                                addr_inc; // RULE8

  // settings are captured at burst start and held for the whole burst
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_on   <= 1'b0;
      fetch_addr <= '0;
      fetch_cnt  <= 5'h00;
      snap_wrap  <= 1'b1;
      snap_len   <= 3'h0;
    end else if (start) begin
      fetch_on   <= 1'b1;
      fetch_addr <= link_addr;
      fetch_cnt  <= 5'h00;
      snap_wrap  <= burst_read_configuration[`BRC_WRAP_BIT]; // RULE13
      snap_len   <= burst_read_configuration[`BRC_LEN_HI:`BRC_LEN_LO]; // RULE13
    end else if (!ce_on) begin
      fetch_on   <= 1'b0;
    end else if (fetch_push && fifo_in_ready) begin
      fetch_addr <= next_addr;
      if (!linear_done) fetch_cnt <= fetch_cnt + 5'h01;
    end
  end

  brc_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (start | ~ce_on),
    .in_data_i   (arr[fetch_addr]),
    .in_valid_i  (fetch_push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .count_o     (fifo_count)
  );

  // ****************************************
  // link side: latency count and data drive
  // ****************************************
  brc_link_t   link_state;
  logic [3:0]  edge_cnt;
  logic [3:0]  snap_first;
  logic        snap_pol;
  logic        snap_early;
  logic        ready_act;

  wire [3:0] next_edge   = edge_cnt + 4'h1;
  // data must be on the pins after the edge before the one the host samples
  wire       drive_edge  = link_rise & (link_state == LINK_WAIT) & (next_edge == snap_first - 4'h1);
  wire       early_edge  = link_rise & (link_state == LINK_WAIT) & (next_edge == snap_first - 4'h2);
  wire       data_edge   = link_rise & (link_state == LINK_DATA);
  assign fifo_pop = (drive_edge | data_edge) & fifo_out_valid & ce_on & ~start;
  wire       more_words  = (fifo_count > CW'(1)) | fetch_push;

  // burst sequencing on sampled link-clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_state <= LINK_IDLE;
      edge_cnt   <= 4'h0;
      snap_first <= `BRC_EDGES_8;
      snap_pol   <= 1'b1;
      snap_early <= 1'b0;
    end else if (start) begin
      link_state <= LINK_WAIT;
      edge_cnt   <= 4'h0;
      snap_first <= first_edge(burst_read_configuration[`BRC_WAIT_HI:`BRC_WAIT_LO]); // RULE13
      snap_pol   <= burst_read_configuration[`BRC_POL_BIT]; // RULE13
      snap_early <= ~burst_read_configuration[`BRC_TIMING_BIT]; // RULE13
    end else if (!ce_on) begin
      link_state <= LINK_IDLE;
    end else if (link_rise) begin
      unique case (link_state)
        LINK_IDLE: edge_cnt <= 4'h0;
        LINK_WAIT: begin
          edge_cnt <= next_edge;
          if (drive_edge) link_state <= LINK_DATA;
        end
        LINK_DATA: edge_cnt <= edge_cnt;
      endcase
    end
  end

  // ready: with data, or one link cycle ahead of it
  always_ff @(posedge clk_i) begin
    if (rst_i || start || !ce_on) begin
      ready_act <= 1'b0;
    end else if (snap_early) begin
      if (early_edge) ready_act <= 1'b1; // RULE5
      else if (drive_edge | data_edge) ready_act <= more_words; // RULE5
    end else if (drive_edge | data_edge) begin
      ready_act <= fifo_out_valid; // RULE5
    end
  end

  // pins; an empty fifo holds the last word and lowers ready
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      burst_data_o    <= 16'h0000;
      burst_data_oe_o <= 1'b0;
      ready_o         <= 1'b0;
    end else begin
      if (fifo_pop) burst_data_o <= fifo_out; // RULE1 RULE2 RULE3
      burst_data_oe_o <= ce_on & oe_on;
      ready_o         <= snap_pol ? ready_act : ~ready_act; // RULE4
    end
  end

  // status: bit0 burst open, bit1 data phase, bit2 fixed burst finished
  assign status_word = {fetch_cnt, 3'h0, fifo_out_valid, 4'h0,
                        linear_done, link_state == LINK_DATA, link_state != LINK_IDLE};
endmodule : brc_burst_read_config
`default_nettype wire

// ==== brc_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit classic Wishbone, word-aligned byte addresses
// Notes:   definitions only
`ifndef BRC_DEFS_SVH
`define BRC_DEFS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define BRC_OFF_CONFIG     4'h0
`define BRC_OFF_STATUS     4'h4
`define BRC_OFF_ARR_INDEX  4'h8
`define BRC_OFF_ARR_DATA   4'hc
// ****************************************
// configuration field positions
// ****************************************
`define BRC_WAIT_HI        14
`define BRC_WAIT_LO        11
`define BRC_POL_BIT        10
`define BRC_RES9_BIT       9
`define BRC_TIMING_BIT     8
`define BRC_RES7_BIT       7
`define BRC_MODE_BIT       6
`define BRC_WRAP_BIT       3
`define BRC_LEN_HI         2
`define BRC_LEN_LO         0
// ****************************************
// reset values and codes
// ****************************************
`define BRC_CONFIG_RESET   16'h47c8
`define BRC_CONFIG_WMASK   16'h7fbf
`define BRC_MODE_LEGACY    16'h0040
`define BRC_WAIT_6         4'h4
`define BRC_WAIT_7         4'h5
`define BRC_WAIT_8         4'h8
`define BRC_WAIT_9         4'h9
`define BRC_LEN_8          3'h2
`define BRC_LEN_16         3'h3
// ****************************************
// timing counts (rising link-clock edges)
// ****************************************
`define BRC_EDGES_6        4'h6
`define BRC_EDGES_7        4'h7
`define BRC_EDGES_8        4'h8
`define BRC_EDGES_9        4'h9
`endif

// ==== brc_pkg.sv ====
// Purpose: shared types of the burst read block
// Assumes: nothing
// Notes:   constants live in brc_defs.svh
package brc_pkg;
  typedef enum logic [1:0] {LINK_IDLE, LINK_WAIT, LINK_DATA} brc_link_t;
endpackage : brc_pkg

// ==== brc_burst_read_config_properties.sv ====
// Purpose: port-level checks of the burst read block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   sync depth of the link pins taken as at most 4 cycles
`timescale 1ns/100ps
`default_nettype none
// ****
// checker
// ****
module brc_burst_read_config_properties (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // link
  input wire logic        burst_clk_i,
  input wire logic        chip_enable_n_i,
  input wire logic        output_enable_n_i,
  input wire logic [15:0] burst_data_o,
  input wire logic        burst_data_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers: fixed one-cycle latency, one-cycle pulse
  a_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_mode_reads_one: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[6] && !wb_dat_o[15])
    else $error("mode bit not legacy");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // pins are driven only while selected; allow for the synchronisers
  a_oe_off_ce: assert property (chip_enable_n_i [*5] |-> !burst_data_oe_o)
    else $error("drives while deselected");
  a_oe_off_oe: assert property (output_enable_n_i [*5] |-> !burst_data_oe_o)
    else $error("drives while output off");
  a_oe_on: assert property ((!chip_enable_n_i && !output_enable_n_i) [*5] |-> burst_data_oe_o)
    else $error("not driving when asked");
  // words only move on a link-clock edge
  a_data_hold: assert property ($stable(burst_clk_i) [*6] |-> $stable(burst_data_o))
    else $error("data moved without edge");
endmodule : brc_burst_read_config_properties
bind brc_burst_read_config brc_burst_read_config_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .burst_clk_i(burst_clk_i), .chip_enable_n_i(chip_enable_n_i),
  .output_enable_n_i(output_enable_n_i), .burst_data_o(burst_data_o),
  .burst_data_oe_o(burst_data_oe_o));
`default_nettype wire

// ==== brc_host_model.sv ====
// Purpose: host controller driving the burst link
// Assumes: link clock of 8 system cycles, still between bursts
// Notes:   address lines carry the inverse once latched
`timescale 1ns/100ps
`default_nettype none
// ****
// host
// ****
module brc_host_model (
  // system clock
  input  wire logic        clk_i,
  // link pins driven
  output logic             burst_clk_o,
  output logic             ce_n_o,
  output logic             latch_n_o,
  output logic             oe_n_o,
  output logic [5:0]       addr_o,
  // link pins sampled
  input  wire logic [15:0] data_i,
  input  wire logic        ready_i
);
  logic [15:0] dq [$];
  logic        rq [$];
  initial begin
    {burst_clk_o, ce_n_o, latch_n_o, oe_n_o} = 4'h7;
    addr_o = 6'h2a;
  end
  // ready kept from edge lat-1, words from edge lat on
  task automatic burst(input logic [5:0] a, input int lat, input int n);
    int e;
    dq = {};
    rq = {};
    @(posedge clk_i);
    {ce_n_o, latch_n_o, oe_n_o} <= 3'h0;
    addr_o <= a;
    for (e = 0; e < lat + n; e++) begin
      repeat (4) @(posedge clk_i);
      if (e >= lat - 1) rq.push_back(ready_i);
      if (e >= lat) dq.push_back(data_i);
      burst_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      burst_clk_o <= 1'b0;
      latch_n_o <= 1'b1;
      addr_o <= ~a;
    end
    {ce_n_o, oe_n_o} <= 2'h3;
  endtask : burst
endmodule : brc_host_model
`default_nettype wire

// ==== brc_burst_read_config_tb.sv ====
// Purpose: self-checking bench of the burst read block
// Assumes: host model drives the link, bench the register bus
// Notes:   array words 0 to 39 hold 5a00 plus i, the rest are never loaded
`timescale 1ns/100ps
`include "brc_defs.svh"
`default_nettype none
// ****
// bench
// ****
module brc_burst_read_config_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, dat_o;
  logic        ack, bclk, ce_n, al_n, oe_n, doe, rdy;
  logic [5:0]  addr;
  logic [15:0] bdat;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc_cnt = 0;
  always #10 clk_i = ~clk_i;
  brc_burst_read_config u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .burst_clk_i(bclk), .chip_enable_n_i(ce_n),
    .addr_latch_n_i(al_n), .output_enable_n_i(oe_n), .addr_i(addr),
    .burst_data_o(bdat), .burst_data_oe_o(doe), .ready_o(rdy));
  brc_host_model u_host (.clk_i(clk_i), .burst_clk_o(bclk), .ce_n_o(ce_n),
    .latch_n_o(al_n), .oe_n_o(oe_n), .addr_o(addr), .data_i(bdat), .ready_i(rdy));
  task automatic end_of_test();
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
  endtask : wb
  // reserved bits nine and seven always written as 1
  function automatic logic [15:0] cfg(input logic [3:0] ws, input logic pol, tim, wrap,
                                      input logic [2:0] len);
    return {1'b0, ws, pol, 1'b1, tim, 2'h3, 2'h0, wrap, len};
  endfunction : cfg
  // grp: wrap group size, lim: words before the address stops
  task automatic run(input logic [15:0] c, input int a, lat, n, grp, lim);
    int k, x;
    logic s;
    wb(1'b1, `BRC_OFF_CONFIG, {16'h0, c});
    u_host.burst(a[5:0], lat, n);
    cmp({31'h0, u_host.rq[0]}, {31'h0, c[8] ? ~c[10] : c[10]});
    for (k = 0; k < n; k++) begin
      s = lim != 0 && k >= lim;
      x = s ? a + lim - 1 : grp ? (a & ~(grp - 1)) | ((a + k) & (grp - 1)) : a + k;
      cmp({16'h0, u_host.dq[k]}, {16'h0, 16'h5a00 + x[15:0]});
      cmp({31'h0, u_host.rq[k + 1]}, {31'h0, s ? ~c[10] : c[10]});
    end
  endtask : run
  // cut a hang short
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 4000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin : main
    logic [3:0] ws [4];
    int         i;
    ws = '{`BRC_WAIT_6, `BRC_WAIT_7, `BRC_WAIT_8, `BRC_WAIT_9};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, `BRC_OFF_CONFIG, 32'h0);
    cmp(rdat, 32'h0000_47c8);
    wb(1'b1, `BRC_OFF_CONFIG, 32'h0000_ffff);
    wb(1'b0, `BRC_OFF_CONFIG, 32'h0);
    cmp(rdat, 32'h0000_7fff);
    wb(1'b0, 4'h2, 32'h0);
    cmp(rdat, 32'h0);
    wb(1'b1, `BRC_OFF_ARR_INDEX, 32'h0);
    for (i = 0; i < 40; i++) wb(1'b1, `BRC_OFF_ARR_DATA, 32'h5a00 + i);
    for (i = 0; i < 4; i++) run(cfg(ws[i], 1'b1, 1'b1, 1'b1, 3'h0), 5, i + 6 + (i / 2) * 2 - (i / 2) * 1 - (i / 2), 3, 0, 0);
    run(cfg(`BRC_WAIT_8, 1'b0, 1'b0, 1'b1, 3'h0), 5, 8, 3, 0, 0);
    run(cfg(`BRC_WAIT_6, 1'b1, 1'b1, 1'b1, `BRC_LEN_8), 6, 6, 8, 8, 0);
    run(cfg(`BRC_WAIT_6, 1'b1, 1'b1, 1'b0, `BRC_LEN_8), 6, 6, 9, 0, 8);
    run(cfg(`BRC_WAIT_6, 1'b1, 1'b1, 1'b1, `BRC_LEN_16), 20, 6, 16, 16, 0);
    run(cfg(`BRC_WAIT_6, 1'b1, 1'b1, 1'b0, `BRC_LEN_16), 20, 6, 17, 0, 16);
    // once deselected: sixteen words fetched, fixed burst finished, link idle
    repeat (4) @(posedge clk_i);
    wb(1'b0, `BRC_OFF_STATUS, 32'h0);
    cmp(rdat, 32'h0000_8004);
    // shorter wait written mid-burst must not touch the open burst
    wb(1'b1, `BRC_OFF_CONFIG, {16'h0, cfg(`BRC_WAIT_9, 1'b1, 1'b1, 1'b1, 3'h0)});
    fork
      u_host.burst(6'h03, 9, 2);
      begin
        repeat (20) @(posedge clk_i);
        wb(1'b1, `BRC_OFF_CONFIG, {16'h0, cfg(`BRC_WAIT_6, 1'b1, 1'b1, 1'b1, 3'h0)});
      end
    join
    cmp({16'h0, u_host.dq[0]}, 32'h5a03);
    cmp({31'h0, u_host.rq[0]}, 32'h0);
    end_of_test();
  end
endmodule : brc_burst_read_config_tb
`default_nettype wire
